/* File: hw/hsmt_mode_ctrl.v */
// mode sequencer, conversion timing and channel mux of the hall sensor
//
// Contract
// - the 2-bit compensation select gives 0, 0.12, 0.03 or 0.2 %/degC for all three axes.
// - after power-up the device reaches stand-by 270 us later and is not ready before.
// - waking from sleep takes 50 us to reach stand-by.
// - continuous measuring starts 70 us after the command from stand-by.
// - one single-channel conversion takes 50 us at averaging code 0 and 825 us at code 5.
// - sleep is entered 20 us after the serial clock returns high ending the command.
// - bus transactions are answered only in stand-by or continuous measure.
// - a matching address while asleep wakes the device without an acknowledge.
// - north on y or z and south on x give positive codes, opposite poles negative.
// - the three hall channels and temperature share one converter in turn.
`timescale 1ns/1ps
`default_nettype none
`include "hsmt_defines.vh"

module hsmt_mode_ctrl #(
  parameter        DATA_W       = 12,
  parameter        TW           = 18,
  parameter [TW-1:0] POWER_UP_CYC = `HSMT_CYC(`HSMT_T_POWER_UP_US),
  parameter [TW-1:0] CONV0_CYC    = `HSMT_CYC(`HSMT_T_CONV_AVG0_US),
  parameter [TW-1:0] CONV5_CYC    = `HSMT_CYC(`HSMT_T_CONV_AVG5_US)
) (
  input  wire              sys_clk_in,
  input  wire              rstn_in,
  input  wire              cmd_measure_in,
  input  wire              cmd_standby_in,
  input  wire              cmd_sleep_in,
  input  wire              scl_rise_in,
  input  wire              addr_match_in,
  input  wire              ack_req_in,
  input  wire [2:0]        averaging_select_in,
  input  wire [1:0]        temp_comp_select_in,
  input  wire [3:0]        chan_enable_in,
  input  wire              x_pole_south_in,
  input  wire              y_pole_north_in,
  input  wire              z_pole_north_in,
  input  wire [DATA_W-2:0] field_mag_in,
  input  wire [DATA_W-1:0] adc_sample_in,
  output reg  [2:0]        mode_out,
  output wire              ready_out,
  output wire              bus_accept_out,
  output wire              ack_out,
  output reg  [4:0]        temp_coeff_out,
  output reg  [1:0]        adc_chan_out,
  output reg               conv_active_out,
  output reg               result_valid_out,
  output reg  [1:0]        result_chan_out,
  output reg  [DATA_W-1:0] result_data_out
);

  localparam [TW-1:0] WAKE_CYC  = `HSMT_CYC(`HSMT_T_WAKE_US);
  localparam [TW-1:0] START_CYC = `HSMT_CYC(`HSMT_T_START_MEAS_US);
  localparam [TW-1:0] SLEEP_CYC = `HSMT_CYC(`HSMT_T_GO_SLEEP_US);
  localparam [TW-1:0] AVG_STEPS = {{(TW-3){1'b0}}, `HSMT_AVG_CODE_MAX};

  reg  [2:0]    next_mode;
  reg           sleep_pending;
  reg           tmr_load;
  reg  [TW-1:0] tmr_count;
  wire          tmr_done;
  reg           conv_first;
  reg  [1:0]    next_chan;

  // ----------------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------------
  // conversion length grows linearly between the two timed codes
  function [TW-1:0] conv_cycles;
    input [2:0] avg;
    reg   [2:0] a;
    begin
      a = (avg > `HSMT_AVG_CODE_MAX) ? `HSMT_AVG_CODE_MAX : avg;
      conv_cycles = CONV0_CYC + ((CONV5_CYC - CONV0_CYC) / AVG_STEPS) * {{(TW-3){1'b0}}, a};
    end
  endfunction

  // next enabled channel after cur, wrapping; cur itself if alone
  function [1:0] pick_next;
    input [1:0] cur;
    input [3:0] en;
    reg   [1:0] c;
    reg   [1:0] res;
    reg         hit;
    integer     i;
    begin
      res = cur;
      hit = 1'b0;
      for (i = 1; i <= 4; i = i + 1) begin
        c = cur + i[1:0];
        if (!hit && en[c]) begin
          res = c;
          hit = 1'b1;
        end
      end
      pick_next = res;
    end
  endfunction

  // ----------------------------------------------------------------------
  // interval timer
  // ----------------------------------------------------------------------
  hsmt_delay_timer #(
    .WIDTH     (TW)
  ) u_timer (
    .sys_clk_in(sys_clk_in),
    .rstn_in   (rstn_in),
    .load_in   (tmr_load),
    .count_in  (tmr_count),
    .done_out  (tmr_done),
    .busy_out  ()
  );

  // ----------------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------------
  // next mode and timer load; only the listed paths exist
  always @* begin
    next_mode = mode_out;
    tmr_load  = 1'b0;
    tmr_count = {TW{1'b0}};
    next_chan = pick_next(adc_chan_out, chan_enable_in);
    case (mode_out)
      `HSMT_ST_POWER_UP: begin
        if (tmr_done) next_mode = `HSMT_ST_STANDBY;
      end
      `HSMT_ST_SLEEP: begin
        if (addr_match_in) begin
          next_mode = `HSMT_ST_WAKING;
          tmr_load  = 1'b1;
          tmr_count = WAKE_CYC;
        end
      end
      `HSMT_ST_WAKING: begin
        if (tmr_done) next_mode = `HSMT_ST_STANDBY;
      end
      `HSMT_ST_STANDBY: begin
        if (cmd_measure_in && chan_enable_in != 4'h0) begin
          next_mode = `HSMT_ST_STARTING;
          tmr_load  = 1'b1;
          tmr_count = START_CYC;
        end
      end
      `HSMT_ST_STARTING: begin
        if (tmr_done) begin
          next_mode = `HSMT_ST_MEASURE;
          tmr_load  = 1'b1;
          tmr_count = conv_cycles(averaging_select_in);
          next_chan = pick_next(2'h3, chan_enable_in);
        end
      end
      `HSMT_ST_MEASURE: begin
        if (cmd_standby_in) begin
          next_mode = `HSMT_ST_STANDBY;
        end else if (tmr_done) begin
          tmr_load  = 1'b1; // back to back conversions
          tmr_count = conv_cycles(averaging_select_in);
        end
      end
      `HSMT_ST_GOING_SLEEP: begin
        if (tmr_done) next_mode = `HSMT_ST_SLEEP;
      end
      default: next_mode = `HSMT_ST_STANDBY;
    endcase
    // sleep request counts from the scl rise that ends the transfer
    if (sleep_pending && scl_rise_in &&
        (mode_out == `HSMT_ST_STANDBY || mode_out == `HSMT_ST_MEASURE)) begin
      next_mode = `HSMT_ST_GOING_SLEEP;
      tmr_load  = 1'b1;
      tmr_count = SLEEP_CYC;
    end
    // power-up load rides on the reset release cycle
    if (mode_out == `HSMT_ST_POWER_UP && !conv_first) begin
      tmr_load  = 1'b1;
      tmr_count = POWER_UP_CYC;
    end
  end

  // state, sleep request latch and power-up start flag
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_out      <= `HSMT_ST_POWER_UP;
      sleep_pending <= 1'b0;
      conv_first    <= 1'b0;
    end else begin
      mode_out   <= next_mode;
      conv_first <= 1'b1;
      if (cmd_sleep_in && bus_accept_out) begin
        sleep_pending <= 1'b1;
      end else if (next_mode == `HSMT_ST_GOING_SLEEP) begin
        sleep_pending <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // bus acceptance
  // ----------------------------------------------------------------------
  assign ready_out      = (mode_out == `HSMT_ST_STANDBY) || (mode_out == `HSMT_ST_MEASURE);
  assign bus_accept_out = ready_out;
  // sleeping address wakes but never acks, the controller expects the nack
  assign ack_out        = ack_req_in && ready_out;

  // ----------------------------------------------------------------------
  // shared converter channel and results
  // ----------------------------------------------------------------------
  // one converter, channels walked in turn
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      adc_chan_out     <= `HSMT_CH_X;
      conv_active_out  <= 1'b0;
      result_valid_out <= 1'b0;
      result_chan_out  <= `HSMT_CH_X;
      result_data_out  <= {DATA_W{1'b0}};
    end else begin
      conv_active_out  <= (next_mode == `HSMT_ST_MEASURE);
      result_valid_out <= 1'b0;
      if (tmr_load && next_mode == `HSMT_ST_MEASURE) begin
        adc_chan_out <= next_chan;
      end
      if (mode_out == `HSMT_ST_MEASURE && tmr_done && !cmd_standby_in) begin
        result_valid_out <= 1'b1;
        result_chan_out  <= adc_chan_out;
        case (adc_chan_out)
          // south on x, north on y and z read positive
          `HSMT_CH_X: result_data_out <= x_pole_south_in ?
                                         {1'b0, field_mag_in} : -{1'b0, field_mag_in};
          `HSMT_CH_Y: result_data_out <= y_pole_north_in ?
                                         {1'b0, field_mag_in} : -{1'b0, field_mag_in};
          `HSMT_CH_Z: result_data_out <= z_pole_north_in ?
                                         {1'b0, field_mag_in} : -{1'b0, field_mag_in};
          default:    result_data_out <= adc_sample_in;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // temperature compensation coefficient
  // ----------------------------------------------------------------------
  // one coefficient shared by x, y and z
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      temp_coeff_out <= `HSMT_TC_VAL_NONE;
    end else begin
      case (temp_comp_select_in)
        `HSMT_TC_012: temp_coeff_out <= `HSMT_TC_VAL_012;
        `HSMT_TC_003: temp_coeff_out <= `HSMT_TC_VAL_003;
        `HSMT_TC_020: temp_coeff_out <= `HSMT_TC_VAL_020;
        default:      temp_coeff_out <= `HSMT_TC_VAL_NONE;
      endcase
    end
  end

endmodule // hsmt_mode_ctrl

`default_nettype wire

/* File: hw/hsmt_defines.vh */
// constants for the hall sensor mode and conversion timing block
`ifndef HSMT_DEFINES_VH
`define HSMT_DEFINES_VH

// ----------------------------------------------------------------------
// clock and timing figures
// ----------------------------------------------------------------------
`define HSMT_CLK_MHZ          200
`define HSMT_T_POWER_UP_US    270
`define HSMT_T_WAKE_US        50
`define HSMT_T_START_MEAS_US  70
`define HSMT_T_CONV_AVG0_US   50
`define HSMT_T_CONV_AVG5_US   825
`define HSMT_T_GO_SLEEP_US    20
`define HSMT_CYC(us)          ((us) * `HSMT_CLK_MHZ)

// ----------------------------------------------------------------------
// mode state codes
// ----------------------------------------------------------------------
`define HSMT_ST_POWER_UP      3'h0
`define HSMT_ST_SLEEP         3'h1
`define HSMT_ST_WAKING        3'h2
`define HSMT_ST_STANDBY       3'h3
`define HSMT_ST_STARTING      3'h4
`define HSMT_ST_MEASURE       3'h5
`define HSMT_ST_GOING_SLEEP   3'h6

// ----------------------------------------------------------------------
// field codes
// ----------------------------------------------------------------------
`define HSMT_AVG_CODE_MAX     3'h5
`define HSMT_TC_NONE          2'h0
`define HSMT_TC_012           2'h1
`define HSMT_TC_003           2'h2
`define HSMT_TC_020           2'h3
// compensation coefficients in units of 0.01 %/degC
`define HSMT_TC_VAL_NONE      5'h00
`define HSMT_TC_VAL_012       5'h0c
`define HSMT_TC_VAL_003       5'h03
`define HSMT_TC_VAL_020       5'h14
`define HSMT_CH_X             2'h0
`define HSMT_CH_Y             2'h1
`define HSMT_CH_Z             2'h2
`define HSMT_CH_TEMP          2'h3

`endif

/* File: hw/hsmt_delay_timer.v */
// down counter that measures one mode or conversion interval
`timescale 1ns/1ps
`default_nettype none

module hsmt_delay_timer #(
  parameter WIDTH = 18
) (
  input  wire             sys_clk_in,
  input  wire             rstn_in,
  input  wire             load_in,
  input  wire [WIDTH-1:0] count_in,
  output wire             done_out,
  output wire             busy_out
);

  reg [WIDTH-1:0] remain;

  // ----------------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------------
  // load wins over counting so a restart is never missed
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      remain <= {WIDTH{1'b0}};
    end else if (load_in) begin
      remain <= count_in;
    end else if (remain != {WIDTH{1'b0}}) begin
      remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // no load term here: the sequencer derives its load from done, a loop otherwise
  assign done_out = (remain == {{(WIDTH-1){1'b0}}, 1'b1});
  assign busy_out = (remain != {WIDTH{1'b0}});

endmodule // hsmt_delay_timer

`default_nettype wire

/* File: dv/hsmt_mode_monitor.sv */
// assertion checker of mode timing and result rules
`timescale 1ns/1ps
`default_nettype none
`include "hsmt_defines.vh"
module hsmt_mode_monitor #(
  parameter          DATA_W       = 12,
  parameter          TW           = 18,
  parameter [TW-1:0] POWER_UP_CYC = 100,
  parameter [TW-1:0] CONV0_CYC    = 20,
  parameter [TW-1:0] CONV5_CYC    = 120
) (
  input wire logic              sys_clk_in,
  input wire logic              rstn_in,
  input wire logic              addr_match_in,
  input wire logic              ack_req_in,
  input wire logic [2:0]        averaging_select_in,
  input wire logic [1:0]        temp_comp_select_in,
  input wire logic [3:0]        chan_enable_in,
  input wire logic              x_pole_south_in,
  input wire logic              y_pole_north_in,
  input wire logic              z_pole_north_in,
  input wire logic [DATA_W-2:0] field_mag_in,
  input wire logic [2:0]        mode_out,
  input wire logic              ack_out,
  input wire logic [4:0]        temp_coeff_out,
  input wire logic              result_valid_out,
  input wire logic [1:0]        result_chan_out,
  input wire logic [DATA_W-1:0] result_data_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  // codes above five clamp, so the expected length clamps too
  wire [2:0]    avg  = averaging_select_in > 3'h5 ? 3'h5 : averaging_select_in;
  wire [TW-1:0] conv = CONV0_CYC + (CONV5_CYC - CONV0_CYC) / TW'(5) * TW'(avg);
  logic [2:0]    prev;
  logic [TW-1:0] dwell;
  logic [TW-1:0] gap;
  // dwell counts cycles in a mode, gap cycles since the last result
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prev  <= 3'h0;
      dwell <= '0;
      gap   <= '0;
    end else begin
      prev  <= mode_out;
      dwell <= (mode_out != prev) ? TW'(1) : dwell + TW'(1);
      gap   <= (result_valid_out || mode_out != `HSMT_ST_MEASURE) ? '0 : gap + TW'(1);
    end
  end
  function automatic logic [4:0] tc(input logic [1:0] s);
    return s[1] ? (s[0] ? 5'h14 : 5'h03) : (s[0] ? 5'h0c : 5'h00);
  endfunction
  sequence s_move(a, b);
    $past(mode_out) == a && mode_out == b;
  endsequence
  // timing is loose by a few cycles for the load and decode edges
  property p_dwell(a, b, n);
    s_move(a, b) |-> dwell + 4 >= n && dwell <= n + 4;
  endproperty
  a_powerup_time: assert property (
    p_dwell(`HSMT_ST_POWER_UP, `HSMT_ST_STANDBY, POWER_UP_CYC)) else $error("power-up time off");
  a_wake_time: assert property (
    p_dwell(`HSMT_ST_WAKING, `HSMT_ST_STANDBY, 10000)) else $error("wake time off");
  a_start_time: assert property (
    p_dwell(`HSMT_ST_STARTING, `HSMT_ST_MEASURE, 14000)) else $error("start time off");
  a_sleep_time: assert property (
    p_dwell(`HSMT_ST_GOING_SLEEP, `HSMT_ST_SLEEP, 4000)) else $error("sleep time off");
  a_conv_time: assert property (
    result_valid_out && $onehot(chan_enable_in) |-> gap + 3 >= conv && gap <= conv + 3)
    else $error("conversion time off");
  a_ack_gate: assert property (
    ack_out == (ack_req_in && (mode_out == `HSMT_ST_STANDBY || mode_out == `HSMT_ST_MEASURE)))
    else $error("ack outside ready");
  a_wake_nack: assert property (
    mode_out == `HSMT_ST_SLEEP && addr_match_in |-> !ack_out ##1 mode_out == `HSMT_ST_WAKING)
    else $error("wake address mishandled");
  a_tc_map: assert property (
    $past(rstn_in) |-> temp_coeff_out == tc($past(temp_comp_select_in)))
    else $error("coefficient wrong");
  a_mux_chan: assert property (
    result_valid_out |-> chan_enable_in[result_chan_out]) else $error("disabled channel");
  a_pole_sign: assert property (
    result_valid_out && result_chan_out != `HSMT_CH_TEMP && field_mag_in != 0 |->
    result_data_out[DATA_W-1] != (result_chan_out == `HSMT_CH_X ? x_pole_south_in :
      result_chan_out == `HSMT_CH_Y ? y_pole_north_in : z_pole_north_in))
    else $error("field sign wrong");
endmodule // hsmt_mode_monitor
bind hsmt_mode_ctrl hsmt_mode_monitor #(.DATA_W(DATA_W), .TW(TW), .POWER_UP_CYC(POWER_UP_CYC),
  .CONV0_CYC(CONV0_CYC), .CONV5_CYC(CONV5_CYC)) mon_i (.sys_clk_in(sys_clk_in),
  .rstn_in(rstn_in), .addr_match_in(addr_match_in), .ack_req_in(ack_req_in),
  .averaging_select_in(averaging_select_in), .temp_comp_select_in(temp_comp_select_in),
  .chan_enable_in(chan_enable_in), .x_pole_south_in(x_pole_south_in),
  .y_pole_north_in(y_pole_north_in), .z_pole_north_in(z_pole_north_in),
  .field_mag_in(field_mag_in), .mode_out(mode_out), .ack_out(ack_out),
  .temp_coeff_out(temp_coeff_out), .result_valid_out(result_valid_out),
  .result_chan_out(result_chan_out), .result_data_out(result_data_out));
`default_nettype wire

/* File: dv/hsmt_i2c_host_model.sv */
// behavioural bus controller on the far side of the sequencer
`timescale 1ns/1ps
`default_nettype none
module hsmt_i2c_host_model (
  input  wire logic sys_clk_in,
  input  wire logic ack_in,
  output var  logic addr_match_out,
  output var  logic ack_req_out,
  output var  logic cmd_sleep_out,
  output var  logic scl_rise_out
);
  initial {addr_match_out, ack_req_out, cmd_sleep_out, scl_rise_out} = 4'h0;
  // address the device; a nack from a sleeper is expected, not an error
  task automatic address(output logic acked);
    @(posedge sys_clk_in);
    #1 {addr_match_out, ack_req_out} = 2'h3;
    @(posedge sys_clk_in);
    acked = ack_in;
    #1 {addr_match_out, ack_req_out} = 2'h0;
  endtask
  // sleep command first, scl returns high only once the transfer ends
  task automatic go_sleep;
    @(posedge sys_clk_in);
    #1 cmd_sleep_out = 1'b1;
    @(posedge sys_clk_in);
    #1 cmd_sleep_out = 1'b0;
    repeat (3) @(posedge sys_clk_in);
    #1 scl_rise_out = 1'b1;
    @(posedge sys_clk_in);
    #1 scl_rise_out = 1'b0;
  endtask
endmodule // hsmt_i2c_host_model
`default_nettype wire

/* File: dv/hsmt_mode_ctrl_tb.sv */
// self-checking testbench of the hall sensor mode sequencer
`timescale 1ns/1ps
`default_nettype none
`include "hsmt_defines.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module hsmt_mode_ctrl_tb;
  logic        clk  = 1'b0;
  logic        rstn = 1'b0;
  logic        meas = 1'b0;
  logic        stby = 1'b0;
  logic        ok;
  logic [2:0]  avg  = 3'h0;
  logic [1:0]  tcs  = 2'h0;
  logic [3:0]  en   = 4'h1;
  logic [2:0]  pol  = 3'h0;
  logic [10:0] mag  = 11'h1;
  logic [11:0] adc  = 12'h0;
  logic [1:0]  seq [4] = '{2'h0, 2'h1, 2'h3, 2'h0};
  wire  [2:0]  mode;
  wire  [4:0]  tco;
  wire  [1:0]  rch;
  wire  [11:0] rd;
  wire  [1:0]  ach;
  wire         ack, rv, am, ar, cs, sr;
  wire         rdy, bacc, cact;
  int          fail_count = 0;
  int          check_count = 0;
  int          n;
  always #2.5 clk = ~clk;
  // short counts keep the run small; expectations use the same values
  hsmt_mode_ctrl #(.POWER_UP_CYC(18'h64), .CONV0_CYC(18'h14), .CONV5_CYC(18'h78))
    hsmt_mode_ctrl_i (.sys_clk_in(clk), .rstn_in(rstn), .cmd_measure_in(meas),
    .cmd_standby_in(stby), .cmd_sleep_in(cs), .scl_rise_in(sr), .addr_match_in(am),
    .ack_req_in(ar), .averaging_select_in(avg), .temp_comp_select_in(tcs),
    .chan_enable_in(en), .x_pole_south_in(pol[0]), .y_pole_north_in(pol[1]),
    .z_pole_north_in(pol[2]), .field_mag_in(mag), .adc_sample_in(adc), .mode_out(mode),
    .ready_out(rdy), .bus_accept_out(bacc), .ack_out(ack), .temp_coeff_out(tco),
    .adc_chan_out(ach), .conv_active_out(cact), .result_valid_out(rv), .result_chan_out(rch),
    .result_data_out(rd));
  hsmt_i2c_host_model hsmt_i2c_host_model_i (.sys_clk_in(clk), .ack_in(ack),
    .addr_match_out(am), .ack_req_out(ar), .cmd_sleep_out(cs), .scl_rise_out(sr));
  function automatic logic [4:0] tc_exp(input logic [1:0] s);
    return s[1] ? (s[0] ? 5'h14 : 5'h03) : (s[0] ? 5'h0c : 5'h00);
  endfunction
  // inputs move 1 ns after the edge, outputs are settled by then
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic wait_mode(input logic [2:0] m, input int lim);
    n = 0;
    while (mode !== m && n < lim) begin tick(1); n++; end
    `CHK(mode, m)
  endtask
  task automatic wait_rv;
    n = 0;
    do begin tick(1); n++; end while (rv !== 1'b1 && n < 400);
    `CHK(rv, 1'b1)
  endtask
  task end_of_test;
    if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    n = $urandom(32'hb014);
    tick(16);
    rstn = 1'b1;
    hsmt_i2c_host_model_i.address(ok);
    `CHK(ok, 1'b0)
    `CHK(mode, `HSMT_ST_POWER_UP)
    `CHK(rdy, 1'b0)
    `CHK(bacc, 1'b0)
    wait_mode(`HSMT_ST_STANDBY, 200);
    `CHK(rdy, 1'b1)
    `CHK(bacc, 1'b1)
    for (int c = 0; c < 4; c++) begin
      tcs = c[1:0];
      tick(2);
      `CHK(tco, tc_exp(tcs))
    end
    en = 4'h0;
    pulse(meas);
    tick(2);
    `CHK(mode, `HSMT_ST_STANDBY)
    for (int i = 0; i < 2; i++) begin
      avg = i ? 3'h5 : 3'h0;
      en = 4'h1 << ($urandom % 3);
      pol = 3'($urandom);
      mag = 11'($urandom) | 11'h1;
      pulse(meas);
      `CHK(mode, `HSMT_ST_STARTING)
      wait_mode(`HSMT_ST_MEASURE, 14010);
      `CHK(cact, 1'b1)
      `CHK(4'h1 << ach, en)
      wait_rv;
      wait_rv;
      `CHK(n >= 18 + 20 * avg && n <= 22 + 20 * avg, 1'b1)
      `CHK(rd[11], ~pol[rch])
      pulse(stby);
      `CHK(mode, `HSMT_ST_STANDBY)
      `CHK(cact, 1'b0)
    end
    en = 4'hb;
    avg = 3'($urandom);
    adc = 12'($urandom);
    pulse(meas);
    wait_mode(`HSMT_ST_MEASURE, 14010);
    for (int k = 0; k < 4; k++) begin
      wait_rv;
      `CHK(rch, seq[k])
      if (k < 3) `CHK(ach, seq[k + 1])
      if (seq[k] == 2'h3) `CHK(rd, adc)
    end
    pulse(stby);
    hsmt_i2c_host_model_i.go_sleep;
    wait_mode(`HSMT_ST_SLEEP, 4100);
    hsmt_i2c_host_model_i.address(ok);
    `CHK(ok, 1'b0)
    `CHK(mode, `HSMT_ST_WAKING)
    `CHK(bacc, 1'b0)
    wait_mode(`HSMT_ST_STANDBY, 10100);
    hsmt_i2c_host_model_i.address(ok);
    `CHK(ok, 1'b1)
    end_of_test;
  end
  // watchdog sized well past the longest expected sequence
  initial begin
    tick(80000);
    fail_count++;
    end_of_test;
  end
endmodule // hsmt_mode_ctrl_tb
`default_nettype wire
